// >>> sehnnp_hop_mem.sv
`timescale 1ns/100ps

package sehnnp_pkg;
    // apb register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_NUMER0 = 8'h08;
    localparam logic [7:0] REG_NUMER1 = 8'h0c;
    localparam logic [7:0] REG_REJECT = 8'h10;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0003;
    localparam int CTRL_PARSE_EN_BIT = 0;
    localparam int CTRL_NULL_EN_BIT = 1;
    // extension type codes and fixed lengths
    localparam logic [6:0] EXT_HOP = 7'h0d;
    localparam logic [6:0] EXT_NULL = 7'h0e;
    localparam logic [6:0] EXT_NUMER = 7'h0f;
    localparam logic [7:0] NULL_LEN_WORDS = 8'h01;
    localparam logic [7:0] NUMER_LEN_WORDS = 8'h02;
    localparam logic [7:0] NULL_FLAG_SET = 8'h01;
    localparam logic [7:0] NULL_FLAG_CLEAR = 8'h00;
    // section types
    localparam logic [7:0] SEC_T1 = 8'h01;
    localparam logic [7:0] SEC_T3 = 8'h03;
    localparam logic [7:0] SEC_T5 = 8'h05;
    localparam logic [7:0] SEC_T6 = 8'h06;
    // byte positions inside an extension
    localparam logic [9:0] POS_TYPE = 10'h000;
    localparam logic [9:0] POS_LEN = 10'h001;
    localparam logic [9:0] POS_BODY = 10'h002;
    localparam logic [9:0] POS_NUM_FRAME = 10'h002;
    localparam logic [9:0] POS_NUM_FS0 = 10'h003;
    localparam logic [9:0] POS_NUM_FS1 = 10'h004;
    localparam logic [9:0] POS_NUM_FS2 = 10'h005;
    localparam logic [9:0] POS_NUM_CP0 = 10'h006;
    localparam logic [9:0] POS_NUM_CP1 = 10'h007;
    localparam int SYM_W = 4;
    localparam int BLK_W = 10;
    localparam int MASK_W = 14;

    typedef struct packed {
        logic [SYM_W-1:0] sym;
        logic [BLK_W-1:0] blk;
    } sehnnp_hop_t;

    typedef struct packed {
        logic [7:0] section_type;
        logic [BLK_W-1:0] section_start_block;
        logic [7:0] section_block_count;
        logic [SYM_W-1:0] first_symbol_index;
        logic [SYM_W-1:0] last_symbol_index;
        logic mask_present;
        logic [MASK_W-1:0] symbol_select_mask;
    } sehnnp_sec_t;

    typedef struct packed {
        logic applies;
        logic [BLK_W-1:0] start_block;
        logic [7:0] block_count;
    } sehnnp_ans_t;

    typedef struct packed {
        logic [7:0] frame_layout_code;
        logic [23:0] frequency_shift;
        logic [15:0] guard_prefix_length;
    } sehnnp_numer_t;
endpackage

module sehnnp_hop_mem #(
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic clk,                            // clock
    input wire logic we,                             // write strobe
    input wire logic [AW-1:0] waddr,                 // write address
    input wire sehnnp_pkg::sehnnp_hop_t wdata,       // write data
    input wire logic [AW-1:0] raddr,                 // read address
    output sehnnp_pkg::sehnnp_hop_t rdata            // registered read data
);
    sehnnp_pkg::sehnnp_hop_t mem [DEPTH];
    sehnnp_pkg::sehnnp_hop_t rdata_r;

    generate
        if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_size
            $error("DEPTH must fit in AW address bits");
        end
    endgenerate

    // no reset: contents only read below the written entry count
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata_r <= mem[raddr];
    end

    assign rdata = rdata_r;
endmodule

// >>> sehnnp.sv
`timescale 1ns/100ps

// Notes on behaviour
// - hop extension is type 0x0d, taken only in section types 1, 3, 5
// - hop entry: two reserved bits, 4-bit symbol, block bits 9:8, then bits 7:0
// - hop count is twice the length field; entries 1 to count-1 follow
// - symbols between consecutive hop symbols use that hop's start block
// - block count is the same for every hop
// - closing hop bound is last addressed symbol plus one
// - symbols before the first hop use the section start block
// - with a symbol mask present, only masked symbols are addressed
// - nulling extension is type 0x0e, length 1, section type 5 only
// - weights of a nulled layer are forced to zero after computation
// - indicator zero means a normal layer; field is 8 bits
// - numerology extension is type 0x0f, length 2, section types 5 and 6
// - with section type 6 a zero fft type and zero prefix are accepted
module sehnnp #(
    parameter int HOP_DEPTH = 16,
    parameter int WT_W = 32
) (
    input wire logic pclk,                           // clock
    input wire logic presetn,                        // async reset, active low
    input wire logic psel,                           // apb select
    input wire logic penable,                        // apb enable
    input wire logic pwrite,                         // apb direction
    input wire logic [7:0] paddr,                    // apb byte address
    input wire logic [31:0] pwdata,                  // apb write data
    output logic [31:0] prdata,                      // apb read data
    output logic pready,                             // apb ready
    output logic pslverr,                            // apb error
    input wire logic sec_start,                      // new section description
    input wire sehnnp_pkg::sehnnp_sec_t sec,         // section context
    input wire logic ext_valid,                      // extension byte valid
    input wire logic ext_start,                      // first byte of an extension
    input wire logic [7:0] ext_byte,                 // extension byte
    input wire logic qry_valid,                      // symbol query
    input wire logic [3:0] qry_symbol,               // queried symbol
    output logic qry_ready,                          // query taken when high
    output logic ans_valid,                          // answer pulse
    output sehnnp_pkg::sehnnp_ans_t ans,             // answer
    input wire logic wt_valid_i,                     // computed weight valid
    input wire logic [WT_W-1:0] wt_data_i,           // computed weight
    output logic wt_valid_o,                         // weight out valid
    output logic [WT_W-1:0] wt_data_o,               // weight out
    output logic layer_null_flag,                    // current layer is nulled
    output logic numer_valid,                        // numerology fields held
    output sehnnp_pkg::sehnnp_numer_t numer          // numerology fields
);
    localparam int AW = (HOP_DEPTH > 1) ? $clog2(HOP_DEPTH) : 1;

    generate
        if (HOP_DEPTH < 2 || HOP_DEPTH > 256) begin : g_bad_depth
            $error("HOP_DEPTH must lie in 2..256");
        end
        if (WT_W < 1) begin : g_bad_wt
            $error("WT_W must be positive");
        end
    endgenerate

    function automatic logic [3:0] low_sym(input logic [13:0] m);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 13; i >= 0; i--) begin
            if (m[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [3:0] high_sym(input logic [13:0] m);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 0; i < 14; i++) begin
            if (m[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    typedef enum logic [1:0] {Q_IDLE, Q_RD, Q_CMP, Q_ANS} sehnnp_qst_t;

    // ---------------- register file
    logic [31:0] ctrl_r;
    logic [31:0] prdata_r;
    logic [7:0] rej_cnt_r;
    logic [7:0] rej_cnt_nxt;
    logic ovf_r;
    logic hop_valid_r;
    logic last_ef_r;
    logic [8:0] n_ent_r;

    wire apb_setup = psel && !penable;
    wire apb_wr = psel && penable && pwrite;
    wire hit_ctrl = (paddr == sehnnp_pkg::REG_CTRL);
    wire hit_stat = (paddr == sehnnp_pkg::REG_STATUS);
    wire hit_n0 = (paddr == sehnnp_pkg::REG_NUMER0);
    wire hit_n1 = (paddr == sehnnp_pkg::REG_NUMER1);
    wire hit_rej = (paddr == sehnnp_pkg::REG_REJECT);
    wire mapped = hit_ctrl || hit_stat || hit_n0 || hit_n1 || hit_rej;
    wire parse_en = ctrl_r[sehnnp_pkg::CTRL_PARSE_EN_BIT];
    wire null_en = ctrl_r[sehnnp_pkg::CTRL_NULL_EN_BIT];

    wire [31:0] stat_word = {19'h0, last_ef_r, numer_valid, layer_null_flag, ovf_r,
                             hop_valid_r, n_ent_r[7:0]};
    wire [31:0] rd_mux = hit_ctrl ? ctrl_r :
                         hit_stat ? stat_word :
                         hit_n0 ? {8'h0, numer.frame_layout_code, numer.guard_prefix_length} :
                         hit_n1 ? {8'h0, numer.frequency_shift} :
                         hit_rej ? {24'h0, rej_cnt_r} : 32'h0;

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= sehnnp_pkg::CTRL_RESET;
            prdata_r <= 32'h0;
        end else begin
            if (apb_setup) begin
                prdata_r <= rd_mux;
            end
            if (apb_wr && hit_ctrl) begin
                ctrl_r <= {30'h0, pwdata[1:0]};
            end
        end
    end

    // ---------------- extension byte parser
    logic [9:0] bcnt_r;
    logic [6:0] type_r;
    logic [7:0] len_r;
    logic acc_hop_r;
    logic acc_null_r;
    logic acc_num_r;
    logic [7:0] hi_r;

    wire byte_in = ext_valid && parse_en;
    wire [9:0] pos = ext_start ? sehnnp_pkg::POS_TYPE : bcnt_r;
    wire at_len = byte_in && (pos == sehnnp_pkg::POS_LEN);
    wire [7:0] st = sec.section_type;
    wire st_135 = (st == sehnnp_pkg::SEC_T1) || (st == sehnnp_pkg::SEC_T3) ||
                  (st == sehnnp_pkg::SEC_T5);
    wire ok_hop = (type_r == sehnnp_pkg::EXT_HOP) && st_135 && (ext_byte != 8'h0);
    wire ok_null = (type_r == sehnnp_pkg::EXT_NULL) && (ext_byte == sehnnp_pkg::NULL_LEN_WORDS) &&
                   (st == sehnnp_pkg::SEC_T5);
    wire ok_num = (type_r == sehnnp_pkg::EXT_NUMER) &&
                  (ext_byte == sehnnp_pkg::NUMER_LEN_WORDS) &&
                  ((st == sehnnp_pkg::SEC_T5) || (st == sehnnp_pkg::SEC_T6));
    wire reject = at_len && !(ok_hop || ok_null || ok_num);
    wire body = byte_in && !ext_start && (bcnt_r >= sehnnp_pkg::POS_BODY);
    // the length counts whole words, type and length bytes included
    wire last_byte = body && (bcnt_r == ({len_r, 2'b00} - 10'h1));

    // hop entries: even body bytes hold the high part, odd ones complete the entry
    wire [9:0] k = bcnt_r - sehnnp_pkg::POS_BODY;
    wire [8:0] ent_idx = k[9:1];
    wire hop_byte = body && acc_hop_r;
    wire mem_we = hop_byte && k[0] && (ent_idx < 9'(HOP_DEPTH));
    sehnnp_pkg::sehnnp_hop_t mem_wdata;
    assign mem_wdata.sym = hi_r[5:2];
    assign mem_wdata.blk = {hi_r[1:0], ext_byte};
    // entries 1..2*len-1 in the body
    wire [8:0] ent_total = {len_r, 1'b0} - 9'h1;
    wire hop_done = last_byte && acc_hop_r;

    assign rej_cnt_nxt = reject ? rej_cnt_r + 8'h1 : (apb_wr && hit_rej) ? 8'h0 : rej_cnt_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bcnt_r <= 10'h0;
            type_r <= 7'h0;
            len_r <= 8'h0;
            acc_hop_r <= 1'b0;
            acc_null_r <= 1'b0;
            acc_num_r <= 1'b0;
            hi_r <= 8'h0;
            last_ef_r <= 1'b0;
            rej_cnt_r <= 8'h0;
        end else begin
            rej_cnt_r <= rej_cnt_nxt;
            if (byte_in) begin
                bcnt_r <= pos + 10'h1;
            end
            if (byte_in && ext_start) begin
                type_r <= ext_byte[6:0];
                last_ef_r <= ext_byte[7];
                acc_hop_r <= 1'b0;
                acc_null_r <= 1'b0;
                acc_num_r <= 1'b0;
            end
            if (at_len) begin
                len_r <= ext_byte;
                acc_hop_r <= ok_hop;
                acc_null_r <= ok_null;
                acc_num_r <= ok_num;
            end
            if (hop_byte && !k[0]) begin
                hi_r <= ext_byte;
            end
            if (last_byte) begin
                acc_hop_r <= 1'b0;
                acc_null_r <= 1'b0;
                acc_num_r <= 1'b0;
            end
        end
    end

    // hop table state, cleared for every new section
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hop_valid_r <= 1'b0;
            n_ent_r <= 9'h0;
            ovf_r <= 1'b0;
        end else if (sec_start) begin
            hop_valid_r <= 1'b0;
            n_ent_r <= 9'h0;
            ovf_r <= 1'b0;
        end else if (hop_done) begin
            hop_valid_r <= 1'b1;
            ovf_r <= (ent_total > 9'(HOP_DEPTH));
            // too many entries: keep the first HOP_DEPTH only
            n_ent_r <= (ent_total > 9'(HOP_DEPTH)) ? 9'(HOP_DEPTH) : ent_total;
        end
    end

    // ---------------- nulling and numerology fields
    logic null_r;
    sehnnp_pkg::sehnnp_numer_t numer_r;
    logic numer_valid_r;
    logic [WT_W-1:0] wt_r;
    logic wt_v_r;

    wire null_byte = body && acc_null_r && (bcnt_r == sehnnp_pkg::POS_BODY);
    wire num_byte = body && acc_num_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            null_r <= 1'b0;
            numer_r <= '0;
            numer_valid_r <= 1'b0;
        end else begin
            if (sec_start) begin
                null_r <= 1'b0;
                numer_valid_r <= 1'b0;
            end else if (null_byte) begin
                // only the exact value one nulls; zero and anything else is normal
                null_r <= (ext_byte == sehnnp_pkg::NULL_FLAG_SET);
            end
            // byte after the indicator is reserved and never looked at
            if (num_byte) begin
                case (bcnt_r)
                    sehnnp_pkg::POS_NUM_FRAME: numer_r.frame_layout_code <= ext_byte;
                    sehnnp_pkg::POS_NUM_FS0: numer_r.frequency_shift[23:16] <= ext_byte;
                    sehnnp_pkg::POS_NUM_FS1: numer_r.frequency_shift[15:8] <= ext_byte;
                    sehnnp_pkg::POS_NUM_FS2: numer_r.frequency_shift[7:0] <= ext_byte;
                    sehnnp_pkg::POS_NUM_CP0: numer_r.guard_prefix_length[15:8] <= ext_byte;
                    sehnnp_pkg::POS_NUM_CP1: numer_r.guard_prefix_length[7:0] <= ext_byte;
                    default: ;
                endcase
            end
            // zero fft type and zero prefix pass unchecked, as type 6 allows them
            if (last_byte && acc_num_r && !sec_start) begin
                numer_valid_r <= 1'b1;
            end
        end
    end

    assign layer_null_flag = null_r;
    assign numer = numer_r;
    assign numer_valid = numer_valid_r;

    // weights arrive already computed over all layers; zeroing is applied afterwards
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wt_r <= '0;
            wt_v_r <= 1'b0;
        end else begin
            wt_v_r <= wt_valid_i;
            if (wt_valid_i) begin
                wt_r <= (null_r && null_en) ? '0 : wt_data_i;
            end
        end
    end

    assign wt_valid_o = wt_v_r;
    assign wt_data_o = wt_r;

    // ---------------- symbol query: walk the ordered hop list
    sehnnp_qst_t qst_r;
    logic [8:0] idx_r;
    logic [3:0] qsym_r;
    logic [9:0] best_r;
    sehnnp_pkg::sehnnp_ans_t ans_r;
    sehnnp_pkg::sehnnp_hop_t mem_rdata;

    sehnnp_hop_mem #(
        .DEPTH(HOP_DEPTH),
        .AW(AW)
    ) u_mem (
        .clk(pclk),
        .we(mem_we),
        .waddr(ent_idx[AW-1:0]),
        .wdata(mem_wdata),
        .raddr(idx_r[AW-1:0]),
        .rdata(mem_rdata)
    );

    wire [3:0] first_sym = sec.mask_present ? low_sym(sec.symbol_select_mask) :
                           sec.first_symbol_index;
    wire [3:0] last_sym = sec.mask_present ? high_sym(sec.symbol_select_mask) :
                          sec.last_symbol_index;
    wire [15:0] mask16 = {2'b00, sec.symbol_select_mask};
    // guard bound last+1 means nothing past the last symbol is addressed
    wire addressed = (qsym_r >= first_sym) && (qsym_r <= last_sym) &&
                     (!sec.mask_present || mask16[qsym_r]);
    wire n_empty = !hop_valid_r || (n_ent_r == 9'h0);
    wire hop_hit = (mem_rdata.sym <= qsym_r);
    wire scan_end = !hop_hit || (idx_r + 9'h1 >= n_ent_r);

    assign qry_ready = (qst_r == Q_IDLE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            qst_r <= Q_IDLE;
            idx_r <= 9'h0;
            qsym_r <= 4'h0;
            best_r <= 10'h0;
            ans_r <= '0;
        end else begin
            case (qst_r)
                Q_IDLE: begin
                    if (qry_valid) begin
                        qsym_r <= qry_symbol;
                        idx_r <= 9'h0;
                        best_r <= sec.section_start_block;
                        qst_r <= n_empty ? Q_ANS : Q_RD;
                    end
                end
                Q_RD: begin
                    qst_r <= Q_CMP;
                end
                Q_CMP: begin
                    // list is ordered, so the first later symbol ends the walk
                    if (hop_hit) begin
                        best_r <= mem_rdata.blk;
                    end
                    idx_r <= idx_r + 9'h1;
                    qst_r <= scan_end ? Q_ANS : Q_RD;
                end
                Q_ANS: begin
                    ans_r.applies <= addressed;
                    ans_r.start_block <= best_r;
                    ans_r.block_count <= sec.section_block_count;
                    qst_r <= Q_IDLE;
                end
                default: qst_r <= Q_IDLE;
            endcase
        end
    end

    logic ans_v_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ans_v_r <= 1'b0;
        end else begin
            ans_v_r <= (qst_r == Q_ANS);
        end
    end

    assign ans_valid = ans_v_r;
    assign ans = ans_r;

    // ---------------- checks
    sequence s_query_taken;
        qry_valid && qry_ready;
    endsequence

    sequence s_answer_soon;
        ##[2:40] ans_valid;
    endsequence

    property p_hop_accept;
        @(posedge pclk) disable iff (!presetn)
        at_len && ok_hop |=> acc_hop_r && type_r == sehnnp_pkg::EXT_HOP && st_135;
    endproperty
    a_hop_accept: assert property (p_hop_accept) else $error("hop ext accepted wrongly");

    property p_entry_split;
        @(posedge pclk) disable iff (!presetn)
        mem_we |-> mem_wdata.blk[7:0] == ext_byte && mem_wdata.sym == $past(ext_byte[5:2]);
    endproperty
    a_entry_split: assert property (p_entry_split) else $error("hop entry fields misplaced");

    property p_entry_count;
        @(posedge pclk) disable iff (!presetn)
        hop_done && !sec_start && ent_total <= 9'(HOP_DEPTH) |=> n_ent_r == $past(ent_total);
    endproperty
    a_entry_count: assert property (p_entry_count) else $error("hop count not 2*len-1");

    property p_same_count;
        @(posedge pclk) disable iff (!presetn)
        ans_valid |-> ans.block_count == $past(sec.section_block_count);
    endproperty
    a_same_count: assert property (p_same_count) else $error("block count changed");

    property p_guard;
        @(posedge pclk) disable iff (!presetn)
        ans_valid && ans.applies |-> $past(qsym_r) <= $past(last_sym);
    endproperty
    a_guard: assert property (p_guard) else $error("symbol past guard addressed");

    property p_no_hops;
        @(posedge pclk) disable iff (!presetn)
        s_query_taken ##0 n_empty |=> ##1 ans_valid && ans.start_block == $past(best_r);
    endproperty
    a_no_hops: assert property (p_no_hops) else $error("start block not original");

    property p_null_accept;
        @(posedge pclk) disable iff (!presetn)
        at_len && ok_null |-> st == sehnnp_pkg::SEC_T5 && ext_byte == sehnnp_pkg::NULL_LEN_WORDS;
    endproperty
    a_null_accept: assert property (p_null_accept) else $error("null ext accepted wrongly");

    property p_null_zero;
        @(posedge pclk) disable iff (!presetn)
        wt_valid_i && null_r && null_en |=> wt_valid_o && wt_data_o == '0;
    endproperty
    a_null_zero: assert property (p_null_zero) else $error("nulled layer weight not zero");

    property p_null_value;
        @(posedge pclk) disable iff (!presetn)
        null_byte && !sec_start |=> null_r == ($past(ext_byte) == sehnnp_pkg::NULL_FLAG_SET);
    endproperty
    a_null_value: assert property (p_null_value) else $error("null indicator misread");

    property p_num_accept;
        @(posedge pclk) disable iff (!presetn)
        at_len && ok_num |=> acc_num_r && len_r == sehnnp_pkg::NUMER_LEN_WORDS;
    endproperty
    a_num_accept: assert property (p_num_accept) else $error("numerology ext accepted wrongly");

    property p_answer_bound;
        @(posedge pclk) disable iff (!presetn)
        s_query_taken |-> s_answer_soon;
    endproperty
    a_answer_bound: assert property (p_answer_bound) else $error("query answer late");
endmodule

// >>> sehnnp_du_model.sv
`timescale 1ns/100ps
module sehnnp_du_model (
    input wire logic pclk, // clock
    output logic ext_valid = 1'b0, // byte strobe
    output logic ext_start = 1'b0, // type byte marker
    output logic [7:0] ext_byte = 8'h00 // byte
);
    // one byte per edge, msb byte first, no gaps
    task automatic send(input logic [63:0] m, input int nb);
        for (int i = 0; i < nb; i++) begin
            ext_valid <= 1'b1;
            ext_start <= (i == 0);
            ext_byte <= m[63-8*i -: 8];
            @(posedge pclk);
        end
        ext_valid <= 1'b0;
        ext_start <= 1'b0;
        // released bus must not look like a held byte
        ext_byte <= ~m[71-8*nb -: 8];
    endtask
endmodule

// >>> testbench.sv
`timescale 1ns/100ps
module testbench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sec_start = 1'b0;
    logic qry_valid = 1'b0, wt_valid_i = 1'b0, er;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, wt_data_i = 32'h0, seed = 32'ha7e206f8, prdata, rd, wt_data_o;
    logic [3:0] qry_symbol = 4'h0;
    logic pready, pslverr, qry_ready, ans_valid, wt_valid_o, layer_null_flag, numer_valid;
    logic ext_valid, ext_start;
    logic [7:0] ext_byte;
    sehnnp_pkg::sehnnp_sec_t sec = '0;
    sehnnp_pkg::sehnnp_ans_t ans, e;
    sehnnp_pkg::sehnnp_numer_t numer;
    sehnnp_pkg::sehnnp_ans_t exp_q[$];
    int failures = 0, comparisons = 0;
    always #2 pclk = ~pclk;
    sehnnp u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sec_start(sec_start), .sec(sec), .ext_valid(ext_valid),
        .ext_start(ext_start), .ext_byte(ext_byte), .qry_valid(qry_valid),
        .qry_symbol(qry_symbol), .qry_ready(qry_ready), .ans_valid(ans_valid), .ans(ans),
        .wt_valid_i(wt_valid_i), .wt_data_i(wt_data_i), .wt_valid_o(wt_valid_o),
        .wt_data_o(wt_data_o), .layer_null_flag(layer_null_flag), .numer_valid(numer_valid),
        .numer(numer));
    sehnnp_du_model u_du (.pclk(pclk), .ext_valid(ext_valid), .ext_start(ext_start),
        .ext_byte(ext_byte));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic cmp(input string w, input logic [63:0] ex, input logic [63:0] g);
        comparisons++;
        if (g !== ex) begin
            failures++;
            $display("BAD %s expected %h seen %h", w, ex, g);
        end
    endtask
    task automatic print_verdict;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic guard(input int n);
        if (n >= 99) begin
            failures++;
            print_verdict();
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 99);
        rd = prdata;
        er = pslverr;
        guard(n);
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge: a following call must not drive psel twice in one step
        @(posedge pclk);
    endtask
    task automatic query(input logic [3:0] s, input sehnnp_pkg::sehnnp_ans_t x);
        int n = 0;
        exp_q.push_back(x);
        qry_valid <= 1'b1;
        qry_symbol <= s;
        do begin @(posedge pclk); n++; end while (qry_ready !== 1'b1 && n < 99);
        qry_valid <= 1'b0;
        while (exp_q.size() != 0 && n < 99) begin @(posedge pclk); n++; end
        guard(n);
    endtask
    task automatic weight(input logic nul);
        int n = 0;
        seed = xs(seed);
        wt_valid_i <= 1'b1;
        wt_data_i <= seed;
        @(posedge pclk);
        wt_valid_i <= 1'b0;
        do begin @(posedge pclk); n++; end while (wt_valid_o !== 1'b1 && n < 99);
        guard(n);
        cmp("weight", nul ? 64'h0 : 64'(seed), 64'(wt_data_o));
    endtask
    task automatic newsec(input sehnnp_pkg::sehnnp_sec_t s);
        sec <= s;
        sec_start <= 1'b1;
        @(posedge pclk);
        sec_start <= 1'b0;
        @(posedge pclk);
    endtask
    // a refused answer only has its applies bit checked
    always @(posedge pclk) if (ans_valid === 1'b1) begin
        e = exp_q.size() != 0 ? exp_q.pop_front() : '1;
        cmp("ans", e.applies ? 64'(e) : 64'h0, e.applies ? 64'(ans) : 64'(ans.applies));
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, sehnnp_pkg::REG_CTRL, 32'h0);
        cmp("ctrl", 64'(sehnnp_pkg::CTRL_RESET), 64'(rd));
        apb(1'b0, 8'h40, 32'h0);
        cmp("pslverr", 64'h1, 64'(er));
        newsec('{8'h01, 10'h011, 8'h20, 4'h2, 4'h9, 1'b0, 14'h0});
        u_du.send(64'h0d02_d2ab_1d55_1d55, 8);
        repeat (2) @(posedge pclk);
        apb(1'b0, sehnnp_pkg::REG_STATUS, 32'h0);
        cmp("status", 64'h103, 64'(rd));
        query(4'h2, '{1'b1, 10'h011, 8'h20});
        query(4'h4, '{1'b1, 10'h2ab, 8'h20});
        query(4'h6, '{1'b1, 10'h2ab, 8'h20});
        query(4'h9, '{1'b1, 10'h155, 8'h20});
        query(4'ha, '{1'b0, 10'h155, 8'h20});
        $display("test hop done");
        newsec('{8'h03, 10'h0f0, 8'h08, 4'h3, 4'h8, 1'b1, 14'h0128});
        u_du.send(64'h0d01_1700_0000_0000, 4);
        repeat (2) @(posedge pclk);
        query(4'h3, '{1'b1, 10'h0f0, 8'h08});
        query(4'h4, '{1'b0, 10'h0f0, 8'h08});
        query(4'h8, '{1'b1, 10'h300, 8'h08});
        $display("test mask done");
        newsec('{8'h05, 10'h123, 8'h01, 4'h0, 4'h1, 1'b0, 14'h0});
        u_du.send(64'h0e01_01ff_0000_0000, 4);
        repeat (2) @(posedge pclk);
        cmp("null flag", 64'h1, 64'(layer_null_flag));
        weight(1'b1);
        u_du.send(64'h0e01_0000_0000_0000, 4);
        repeat (2) @(posedge pclk);
        weight(1'b0);
        u_du.send(64'h0f02_a5ab_cdef_1234, 8);
        repeat (2) @(posedge pclk);
        cmp("numer", 64'h0000_a5ab_cdef_1234, 64'(numer));
        apb(1'b0, sehnnp_pkg::REG_NUMER0, 32'h0);
        cmp("numer0", 64'h00a5_1234, 64'(rd));
        query(4'h1, '{1'b1, 10'h123, 8'h01});
        $display("test null and numerology done");
        newsec('{8'h06, 10'h0, 8'h01, 4'h0, 4'h1, 1'b0, 14'h0});
        u_du.send(64'h0f02_0012_3456_0000, 8);
        u_du.send(64'h0d01_1234_0000_0000, 4);
        u_du.send(64'h0e01_0100_0000_0000, 4);
        repeat (2) @(posedge pclk);
        cmp("numer t6", 64'h0001_0012_3456_0000, {15'h0, numer_valid, numer});
        cmp("null t6", 64'h0, 64'(layer_null_flag));
        apb(1'b0, sehnnp_pkg::REG_REJECT, 32'h0);
        cmp("reject", 64'h2, 64'(rd[7:0]));
        apb(1'b1, sehnnp_pkg::REG_REJECT, xs(seed));
        apb(1'b0, sehnnp_pkg::REG_REJECT, 32'h0);
        cmp("reject clr", 64'h0, 64'(rd[7:0]));
        $display("test refusals done");
        print_verdict();
    end
endmodule
